// *** design/phy_ctrl_pkg.sv ***
// Constants, types and helpers for the management register block.
// Assumes a single 250 MHz system clock; management pins arrive unsynchronised.
// Contract
// - Thirty-two management registers are reached directly by address, with no indirection.
// - Entries 0h to Fh take the standard layouts and entries 10h to 1Fh are implementation space.
// - Writing one to bit 15 starts a software reset, and the bit clears itself, defaulting to zero.
// - Writing one to bit 9 restarts negotiation, and the bit then clears itself to zero.
// - Manual speed is bit 6 as MSB and bit 13 as LSB, and it is ignored while negotiation is on.
// - Negotiation enable in bit 12, default one, overrides manual speed and duplex when set.
// - Bit 11 enters power-down, and the link status copy may then go stale.
// - Bit 11 going from one to zero triggers an internal global reset.
// - Bit 10 isolates the PHY from the MAC-side interface, and clearing it restores normal use.
package phy_ctrl_pkg;
    // ****************************************************************
    // Register space
    // ****************************************************************
    localparam int REG_W = 16;
    localparam int ADDR_W = 5;
    localparam int REG_COUNT = 32;
    localparam logic [ADDR_W-1:0] BASIC_CONTROL_ADDR = 5'h00;
    localparam logic [ADDR_W-1:0] VENDOR_BASE_ADDR = 5'h10;
    localparam int BIT_RESET = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_SPEED_LSB = 13;
    localparam int BIT_AN_ENABLE = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_ISOLATE = 10;
    localparam int BIT_AN_RESTART = 9;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_SPEED_MSB = 6;
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    localparam logic [1:0] SPEED_RSVD = 2'h3;
    localparam logic DEF_AN_ENABLE = 1'h1;
    localparam logic DEF_DUPLEX = 1'h1;
    localparam logic DEF_SPEED_LSB = 1'h0;

    // ****************************************************************
    // Management frame
    // ****************************************************************
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [3:0] ADDR_BITS_LAST = 4'h9;
    localparam logic [3:0] DATA_BITS_LAST = 4'hf;
    localparam logic TA_DRIVE_LEVEL = 1'h0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int GRST_TIME_NS = 500;
    localparam int GRST_CYCLES = (GRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOST_WAIT_US = 1000;
    localparam int GRST_CNT_W = 8;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic soft_reset;
        logic loopback;
        logic an_enable;
        logic power_down;
        logic isolate;
        logic an_restart;
        logic duplex;
        logic [1:0] speed;
    } ctrl_t;

    typedef enum logic [2:0] {
        MD_IDLE = 3'h0,
        MD_START = 3'h1,
        MD_OP = 3'h3,
        MD_ADDR = 3'h2,
        MD_TA = 3'h6,
        MD_DATA = 3'h7
    } mdio_state_t;

    // Reserved bits 7 and 5:0 stay zero on readback
    function automatic logic [REG_W-1:0] pack_ctrl(input ctrl_t c);
        logic [REG_W-1:0] w;
        w = '0;
        w[BIT_RESET] = c.soft_reset;
        w[BIT_LOOPBACK] = c.loopback;
        w[BIT_SPEED_LSB] = c.speed[0];
        w[BIT_AN_ENABLE] = c.an_enable;
        w[BIT_POWER_DOWN] = c.power_down;
        w[BIT_ISOLATE] = c.isolate;
        w[BIT_AN_RESTART] = c.an_restart;
        w[BIT_DUPLEX] = c.duplex;
        w[BIT_SPEED_MSB] = c.speed[1];
        return w;
    endfunction

    function automatic ctrl_t default_ctrl(input logic speed_msb);
        ctrl_t c;
        c = '0;
        c.an_enable = DEF_AN_ENABLE;
        c.duplex = DEF_DUPLEX;
        c.speed = {speed_msb, DEF_SPEED_LSB};
        return c;
    endfunction
endpackage

// *** design/reg_space_mem.sv ***
// Plain storage for the directly addressed register entries.
// Assumes a single write port and one registered read port on one clock.
`timescale 1ns/1ps
`default_nettype none
module reg_space_mem #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 5
) (
    input wire logic clk_sys, // System clock
    input wire logic we, // Write strobe
    input wire logic [ADDR_W-1:0] waddr, // Write address
    input wire logic [DATA_W-1:0] wdata, // Write data
    input wire logic [ADDR_W-1:0] raddr, // Read address
    output logic [DATA_W-1:0] rdata_q // Registered read data
);
    logic [DATA_W-1:0] mem [2**ADDR_W];

    // ****************************************************************
    // Storage
    // ****************************************************************
    // No reset on the array; contents are defined only once written
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data always from a register so callers see a fixed latency
    always_ff @(posedge clk_sys) begin
        rdata_q <= mem[raddr];
    end
endmodule
`default_nettype wire

// *** design/phy_basic_control_register.sv ***
// Management slave on the serial management pins with the basic control register.
// Assumes MDC and MDIO come straight from pins; negotiation results come on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module phy_basic_control_register
    import phy_ctrl_pkg::*;
#(
    parameter logic [ADDR_W-1:0] PHY_ADDR = 5'h01,
    parameter logic SPEED_MSB_DEFAULT = 1'h1
) (
    input wire logic clk_sys, // 250 MHz system clock
    input wire logic rst, // Synchronous active-high reset
    input wire logic mdc, // Management clock pin
    input wire logic mdio_i, // Management data pin level
    output logic mdio_o, // Management data driven level
    output logic mdio_oe, // High while driving the data pin
    input wire logic [1:0] an_speed, // Negotiated speed code
    input wire logic an_duplex, // Negotiated duplex
    input wire logic link_up, // Live link indication
    output logic link_up_q, // Link status copy
    output logic loopback_q, // Loopback mode
    output logic isolate_q, // MAC interface isolated
    output logic power_down_q, // Power-down mode
    output logic an_enable_q, // Negotiation enabled
    output logic an_restart_q, // One-cycle negotiation restart
    output logic [1:0] eff_speed_q, // Speed in use
    output logic eff_duplex_q, // Duplex in use
    output logic global_reset_q // Internal global reset
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
    logic mdio_s1_q, mdio_s2_q;
    logic mdc_rise;

    // Two flops per pin; the third mdc stage only feeds edge detection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mdc_s1_q <= 1'h0;
            mdc_s2_q <= 1'h0;
            mdc_s3_q <= 1'h0;
            mdio_s1_q <= 1'h1;
            mdio_s2_q <= 1'h1;
        end else begin
            mdc_s1_q <= mdc;
            mdc_s2_q <= mdc_s1_q;
            mdc_s3_q <= mdc_s2_q;
            mdio_s1_q <= mdio_i;
            mdio_s2_q <= mdio_s1_q;
        end
    end

    assign mdc_rise = mdc_s2_q & ~mdc_s3_q;

    // ****************************************************************
    // Frame decoder
    // ****************************************************************
    mdio_state_t state_q;
    logic [1:0] op_q;
    logic [9:0] addr_sr_q;
    logic [3:0] bit_cnt_q;
    logic [REG_W-1:0] data_sr_q;
    logic ta_first_q;
    logic rd_hit_q;
    logic wr_commit;
    logic [ADDR_W-1:0] reg_addr;
    logic [ADDR_W-1:0] phy_addr;
    logic [REG_W-1:0] mem_rdata;
    logic [REG_W-1:0] rd_word;
    ctrl_t ctrl_q;

    assign phy_addr = addr_sr_q[9:5];
    assign reg_addr = addr_sr_q[4:0];
    assign wr_commit = mdc_rise && state_q == MD_DATA && bit_cnt_q == DATA_BITS_LAST &&
                       op_q == OP_WRITE && phy_addr == PHY_ADDR && !global_reset_q;

    // Every address is plain storage except the basic control entry
    assign rd_word = (reg_addr == BASIC_CONTROL_ADDR) ? pack_ctrl(ctrl_q) : mem_rdata;

    // Frame sequencing; frames are not decoded while the global reset runs
    always_ff @(posedge clk_sys) begin
        if (rst || global_reset_q) begin
            state_q <= MD_IDLE;
            op_q <= 2'h0;
            addr_sr_q <= '0;
            bit_cnt_q <= 4'h0;
            ta_first_q <= 1'h0;
        end else if (mdc_rise) begin
            case (state_q)
                MD_IDLE: begin
                    // Any idle ones then a zero; preamble length is not checked
                    if (!mdio_s2_q) begin
                        state_q <= MD_START;
                    end
                end
                MD_START: begin
                    state_q <= mdio_s2_q ? MD_OP : MD_IDLE;
                    bit_cnt_q <= 4'h0;
                end
                MD_OP: begin
                    op_q <= {op_q[0], mdio_s2_q};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (bit_cnt_q != 4'h0) begin
                        state_q <= MD_ADDR;
                        bit_cnt_q <= 4'h0;
                    end
                end
                MD_ADDR: begin
                    addr_sr_q <= {addr_sr_q[8:0], mdio_s2_q};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (bit_cnt_q == ADDR_BITS_LAST) begin
                        state_q <= (op_q == OP_READ || op_q == OP_WRITE) ? MD_TA : MD_IDLE;
                        ta_first_q <= 1'h1;
                    end
                end
                MD_TA: begin
                    ta_first_q <= 1'h0;
                    if (!ta_first_q) begin
                        state_q <= MD_DATA;
                        bit_cnt_q <= 4'h0;
                    end
                end
                MD_DATA: begin
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (bit_cnt_q == DATA_BITS_LAST) begin
                        state_q <= MD_IDLE;
                    end
                end
                default: begin
                    state_q <= MD_IDLE;
                end
            endcase
        end
    end

    // Data shifter: captures write data, or shifts read data out MSB first
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_sr_q <= '0;
            rd_hit_q <= 1'h0;
        end else if (mdc_rise) begin
            if (state_q == MD_TA && ta_first_q) begin
                data_sr_q <= rd_word;
                rd_hit_q <= op_q == OP_READ && phy_addr == PHY_ADDR && !global_reset_q;
            end else if (state_q == MD_DATA) begin
                data_sr_q <= {data_sr_q[REG_W-2:0], mdio_s2_q};
                if (bit_cnt_q == DATA_BITS_LAST) begin
                    rd_hit_q <= 1'h0;
                end
            end else if (state_q != MD_TA) begin
                // Hit must survive the second turnaround bit, which launches data[15]
                rd_hit_q <= 1'h0;
            end
        end
    end

    // Pin driver changes just after a rising MDC so the host samples it stable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mdio_o <= 1'h1;
            mdio_oe <= 1'h0;
        end else if (mdc_rise) begin
            if (state_q == MD_TA && ta_first_q && op_q == OP_READ &&
                phy_addr == PHY_ADDR && !global_reset_q) begin
                mdio_o <= TA_DRIVE_LEVEL;
                mdio_oe <= 1'h1;
            end else if (rd_hit_q && (state_q == MD_TA || state_q == MD_DATA) &&
                         !(state_q == MD_DATA && bit_cnt_q == DATA_BITS_LAST)) begin
                mdio_o <= (state_q == MD_TA) ? data_sr_q[REG_W-1] : data_sr_q[REG_W-2];
                mdio_oe <= 1'h1;
            end else begin
                mdio_o <= 1'h1;
                mdio_oe <= 1'h0;
            end
        end
    end

    // ****************************************************************
    // Register storage
    // ****************************************************************
    // Standard entries other than basic control, and implementation entries, are held here
    reg_space_mem #(
        .DATA_W(REG_W),
        .ADDR_W(ADDR_W)
    ) u_mem (
        .clk_sys(clk_sys),
        .we(wr_commit && reg_addr != BASIC_CONTROL_ADDR),
        .waddr(reg_addr),
        .wdata({data_sr_q[REG_W-2:0], mdio_s2_q}),
        .raddr(reg_addr),
        .rdata_q(mem_rdata)
    );

    // ****************************************************************
    // Basic control register
    // ****************************************************************
    logic [REG_W-1:0] wr_word;
    logic [GRST_CNT_W-1:0] grst_cnt_q;
    logic grst_start;

    assign wr_word = {data_sr_q[REG_W-2:0], mdio_s2_q};
    assign grst_start = wr_commit && reg_addr == BASIC_CONTROL_ADDR &&
                        (wr_word[BIT_RESET] ||
                         (ctrl_q.power_down && !wr_word[BIT_POWER_DOWN]));

    // Control bits; reserved positions are never stored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= default_ctrl(SPEED_MSB_DEFAULT);
        end else if (global_reset_q && grst_cnt_q == GRST_CNT_W'(1)) begin
            ctrl_q <= default_ctrl(SPEED_MSB_DEFAULT);
        end else if (wr_commit && reg_addr == BASIC_CONTROL_ADDR) begin
            ctrl_q.soft_reset <= wr_word[BIT_RESET];
            ctrl_q.loopback <= wr_word[BIT_LOOPBACK];
            ctrl_q.an_enable <= wr_word[BIT_AN_ENABLE];
            ctrl_q.power_down <= wr_word[BIT_POWER_DOWN];
            ctrl_q.isolate <= wr_word[BIT_ISOLATE];
            ctrl_q.an_restart <= wr_word[BIT_AN_RESTART];
            ctrl_q.duplex <= wr_word[BIT_DUPLEX];
            ctrl_q.speed <= {wr_word[BIT_SPEED_MSB], wr_word[BIT_SPEED_LSB]};
        end else if (ctrl_q.an_restart) begin
            ctrl_q.an_restart <= 1'h0;
        end
    end

    // Global reset length; kept well under the manager's post power-down wait
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            grst_cnt_q <= '0;
            global_reset_q <= 1'h0;
        end else if (grst_start) begin
            grst_cnt_q <= GRST_CNT_W'(GRST_CYCLES);
            global_reset_q <= 1'h1;
        end else if (grst_cnt_q != '0) begin
            grst_cnt_q <= grst_cnt_q - GRST_CNT_W'(1);
            global_reset_q <= grst_cnt_q != GRST_CNT_W'(1);
        end
    end

    // ****************************************************************
    // Mode outputs
    // ****************************************************************
    // Negotiated result wins over the manual bits; reserved manual code runs as 1000
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            loopback_q <= 1'h0;
            isolate_q <= 1'h0;
            power_down_q <= 1'h0;
            an_enable_q <= DEF_AN_ENABLE;
            an_restart_q <= 1'h0;
            eff_speed_q <= SPEED_10;
            eff_duplex_q <= DEF_DUPLEX;
        end else begin
            loopback_q <= ctrl_q.loopback;
            isolate_q <= ctrl_q.isolate;
            power_down_q <= ctrl_q.power_down;
            an_enable_q <= ctrl_q.an_enable;
            an_restart_q <= ctrl_q.an_restart && ctrl_q.an_enable;
            if (ctrl_q.an_enable) begin
                eff_speed_q <= an_speed;
                eff_duplex_q <= an_duplex;
            end else begin
                eff_speed_q <= (ctrl_q.speed == SPEED_RSVD) ? SPEED_1000 : ctrl_q.speed;
                eff_duplex_q <= ctrl_q.duplex;
            end
        end
    end

    // Status copy freezes in power-down, so software must not trust it then
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            link_up_q <= 1'h0;
        end else if (!ctrl_q.power_down) begin
            link_up_q <= link_up;
        end
    end
endmodule
`default_nettype wire

// *** dv/phy_ctrl_checker.sv ***
// Assertion checker for the management register block, seeing its ports only.
// Assumes it is bound into the block; one clock domain with a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module phy_ctrl_checker
    import phy_ctrl_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic mdio_o, // Driven data level
    input wire logic mdio_oe, // Data drive enable
    input wire logic [1:0] an_speed, // Negotiated speed
    input wire logic an_duplex, // Negotiated duplex
    input wire logic an_enable_q, // Negotiation enabled
    input wire logic an_restart_q, // Restart pulse
    input wire logic [1:0] eff_speed_q, // Speed in use
    input wire logic eff_duplex_q, // Duplex in use
    input wire logic power_down_q, // Power-down mode
    input wire logic global_reset_q // Internal global reset
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    int grst_len_q;

    // Length of the running global reset; a plain repetition would be far too long
    always_ff @(posedge clk_sys) begin
        if (rst || !global_reset_q) begin
            grst_len_q <= 0;
        end else begin
            grst_len_q <= grst_len_q + 1;
        end
    end

    property p_restart_pulse;
        $rose(an_restart_q) |=> !an_restart_q [*3];
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart not a pulse");
    property p_an_override;
        an_enable_q && $past(an_enable_q) && !$past(rst) && !global_reset_q
            |-> eff_speed_q == $past(an_speed) && eff_duplex_q == $past(an_duplex);
    endproperty
    a_an_override: assert property (p_an_override) else $error("negotiated mode ignored");
    property p_speed_legal;
        eff_speed_q != SPEED_RSVD;
    endproperty
    a_speed_legal: assert property (p_speed_legal) else $error("reserved speed in use");
    property p_grst_len;
        $fell(global_reset_q) |-> grst_len_q == GRST_CYCLES;
    endproperty
    a_grst_len: assert property (p_grst_len) else $error("global reset length wrong");
    property p_grst_bound;
        global_reset_q |-> grst_len_q < GRST_CYCLES;
    endproperty
    a_grst_bound: assert property (p_grst_bound) else $error("global reset too long");
    property p_pd_exit;
        $fell(power_down_q) |-> ##[0:4] global_reset_q;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("no reset on power-down exit");
    property p_quiet_grst;
        global_reset_q |-> !mdio_oe;
    endproperty
    a_quiet_grst: assert property (p_quiet_grst) else $error("pin driven in reset");
    property p_ta_low;
        $rose(mdio_oe) |-> !mdio_o;
    endproperty
    a_ta_low: assert property (p_ta_low) else $error("turnaround not low");
endmodule
`default_nettype wire

// *** dv/mdio_host.sv ***
// Station management model: drives MDC and MDIO frames, MSB first.
// Assumes the bench resolves the data pin, with a pull-up when nobody drives.
`timescale 1ns/1ps
`default_nettype none
module mdio_host
    import phy_ctrl_pkg::*;
#(
    parameter int HALF = 10,
    parameter int PD_WAIT_NS = 1000000
) (
    input wire logic clk_sys, // System clock
    input wire logic mdio_line, // Resolved data pin level
    output logic mdc, // Management clock
    output logic host_o, // Level driven by the host
    output logic host_oe // High while the host drives
);
    // ****************************************************************
    // Frame engine
    // ****************************************************************
    initial begin
        mdc = 1'b0;
        host_o = 1'b1;
        host_oe = 1'b0;
    end

    // Changes land just after a clock edge, never on it
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One MDC period; MDC stands still between frames
    task automatic bit_cycle(input logic b, output logic smp);
        host_o = b;
        wait_clk(HALF);
        smp = mdio_line;
        mdc = 1'b1;
        wait_clk(HALF);
        mdc = 1'b0;
    endtask

    // Whole 16-bit frames only, direct addressing without indirection
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [45:0] hdr;
        logic s;
        hdr = {32'hffffffff, 2'h1, op, phy, ra};
        rd = 16'h0;
        host_oe = 1'b1;
        for (int i = 45; i >= 0; i--) bit_cycle(hdr[i], s);
        if (op == OP_WRITE) begin
            bit_cycle(1'b1, s);
            bit_cycle(1'b0, s);
            for (int i = 15; i >= 0; i--) bit_cycle(wd[i], s);
        end else begin
            // Released pin reads the pull-up level unless the device answers
            host_oe = 1'b0;
            bit_cycle(1'b1, s);
            bit_cycle(1'b1, s);
            for (int i = 15; i >= 0; i--) begin
                bit_cycle(1'b1, s);
                rd[i] = s;
            end
        end
        host_oe = 1'b0;
        host_o = 1'b1;
    endtask

    // No access at all until the restart after power-down has settled
    task automatic pd_exit_wait();
        wait_clk(PD_WAIT_NS * 1000 / CLK_PERIOD_PS);
    endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the management register block.
// Assumes the host model makes all frames; the data pin has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import phy_ctrl_pkg::*;
();
    // ****************************************************************
    // Bench
    // ****************************************************************
    localparam logic [4:0] PHY = 5'h01;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [1:0] an_speed = SPEED_1000;
    logic an_duplex = 1'b0;
    logic link_up = 1'b1;
    logic mdc, host_o, host_oe, mdio_o, mdio_oe, mdio_line;
    logic link_up_q, loopback_q, isolate_q, power_down_q, an_enable_q, an_restart_q;
    logic eff_duplex_q, global_reset_q;
    logic [1:0] eff_speed_q;
    logic [15:0] n_rst = 16'h0;
    logic [15:0] n_grst = 16'h0;
    int fail_count = 0;
    int checked = 0;

    // Pin level from both drivers, pulled up when released
    assign mdio_line = mdio_oe ? mdio_o : (host_oe ? host_o : 1'b1);

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    phy_basic_control_register #(.PHY_ADDR(PHY)) DUT (
        .clk_sys, .rst, .mdc, .mdio_i(mdio_line), .mdio_o, .mdio_oe, .an_speed, .an_duplex,
        .link_up, .link_up_q, .loopback_q, .isolate_q, .power_down_q, .an_enable_q,
        .an_restart_q, .eff_speed_q, .eff_duplex_q, .global_reset_q
    );
    mdio_host #(.HALF(10), .PD_WAIT_NS(2000)) u_host (
        .clk_sys, .mdio_line, .mdc, .host_o, .host_oe
    );

    // Pulse and span counters that the scenarios clear and read
    always @(posedge clk_sys) begin
        if (an_restart_q === 1'b1) n_rst <= n_rst + 16'h1;
        if (global_reset_q === 1'b1) n_grst <= n_grst + 16'h1;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] x;
        u_host.frame(OP_WRITE, PHY, a, d, x);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] x;
        u_host.frame(OP_READ, PHY, a, 16'h0, x);
        check(x, e);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic t_defaults();
        rd_chk(5'h00, 16'h1140);
        check({10'h0, an_enable_q, eff_duplex_q, eff_speed_q, loopback_q, isolate_q}, 16'h0028);
        $display("defaults done");
    endtask
    task automatic t_storage();
        logic [4:0] addrs [4] = '{5'h01, 5'h0f, 5'h10, 5'h1f};
        foreach (addrs[i]) wr(addrs[i], 16'ha5c3 ^ {11'h0, addrs[i]});
        foreach (addrs[i]) rd_chk(addrs[i], 16'ha5c3 ^ {11'h0, addrs[i]});
        $display("storage done");
    endtask
    // Every manual speed code, with the reserved bits written as ones
    task automatic t_manual();
        logic [1:0] sp [4] = '{SPEED_10, SPEED_100, SPEED_1000, SPEED_1000};
        logic [15:0] d;
        for (int c = 0; c < 4; c++) begin
            d = {2'h0, c[0], 4'h0, c[1] ^ c[0], 1'h0, c[1], 6'h0};
            wr(5'h00, d | 16'h00bf);
            rd_chk(5'h00, d);
            check({13'h0, eff_speed_q, eff_duplex_q}, {13'h0, sp[c], d[8]});
        end
        $display("manual done");
    endtask
    task automatic t_an();
        wr(5'h00, 16'h3000);
        check({13'h0, eff_speed_q, eff_duplex_q}, {13'h0, SPEED_1000, 1'b0});
        an_speed = SPEED_10;
        an_duplex = 1'b1;
        u_host.wait_clk(3);
        check({13'h0, eff_speed_q, eff_duplex_q}, {13'h0, SPEED_10, 1'b1});
        $display("negotiation done");
    endtask
    task automatic t_restart();
        n_rst = 16'h0;
        wr(5'h00, 16'h1200);
        u_host.wait_clk(4);
        check(n_rst, 16'h1);
        rd_chk(5'h00, 16'h1000);
        $display("restart done");
    endtask
    // Link status is checked in power-down only before link_up drops, since the copy may be stale
    task automatic t_power();
        wr(5'h00, 16'h4c00);
        check({12'h0, link_up_q, loopback_q, isolate_q, power_down_q}, 16'h000f);
        link_up = 1'b0;
        n_grst = 16'h0;
        wr(5'h00, 16'h4400);
        u_host.pd_exit_wait();
        check(n_grst, 16'(GRST_CYCLES));
        rd_chk(5'h00, 16'h1140);
        check({13'h0, link_up_q, loopback_q, isolate_q}, 16'h0000);
        $display("power-down done");
    endtask
    task automatic t_soft();
        wr(5'h00, 16'h0100);
        n_grst = 16'h0;
        wr(5'h00, 16'h8000);
        u_host.wait_clk(2 * GRST_CYCLES);
        check(n_grst, 16'(GRST_CYCLES));
        rd_chk(5'h00, 16'h1140);
        $display("soft reset done");
    endtask
    // Frames for another station address must leave the pin and storage alone
    task automatic t_other_phy();
        logic [15:0] x;
        u_host.frame(OP_WRITE, 5'h02, 5'h10, 16'h0000, x);
        u_host.frame(OP_READ, 5'h02, 5'h10, 16'h0000, x);
        check(x, 16'hffff);
        rd_chk(5'h10, 16'ha5d3);
        $display("other address done");
    endtask

    initial begin
        u_host.wait_clk(2);
        rst = 1'b0;
        u_host.wait_clk(4);
        t_defaults();
        t_storage();
        t_manual();
        t_an();
        t_restart();
        t_power();
        t_soft();
        t_other_phy();
        end_of_test();
    end

    // Watchdog, well beyond the roughly 40000 cycles the scenarios take
    initial begin
        repeat (80000) @(posedge clk_sys);
        fail_count++;
        end_of_test();
    end
endmodule

bind phy_basic_control_register phy_ctrl_checker u_chk (
    .clk_sys, .rst, .mdio_o, .mdio_oe, .an_speed, .an_duplex, .an_enable_q, .an_restart_q,
    .eff_speed_q, .eff_duplex_q, .power_down_q, .global_reset_q
);
`default_nettype wire
